/* File: design/otpct_pkg.sv */
// constants for the customer trim register block
package otpct_pkg;
    localparam int unsigned OTPCT_CLK_HZ = 20_000_000;
    localparam logic [5:0] OTPCT_ADDR = 6'h3E;
    localparam int unsigned OTPCT_FRAME_W = 24;
    localparam logic [1:0] OTPCT_CMD_WRITE = 2'h0;
    localparam logic [1:0] OTPCT_CMD_READ = 2'h1;
    localparam int unsigned OTPCT_OP_HI = 23;
    localparam int unsigned OTPCT_OP_LO = 21;
    localparam int unsigned OTPCT_DEF_HI = 20;
    localparam int unsigned OTPCT_DEF_LO = 13;
    localparam int unsigned OTPCT_DONE_BIT = 12;
    localparam logic [23:0] OTPCT_RESET_VAL = 24'h00_0000;
    localparam logic [2:0] OTPCT_OP_STD = 3'h1;
    localparam logic [2:0] OTPCT_OP_MARGIN = 3'h2;
    localparam logic [2:0] OTPCT_OP_BLANK = 3'h3;
    localparam logic [2:0] OTPCT_OP_BURN = 3'h4;
    localparam logic [2:0] OTPCT_OP_EOT = 3'h7;
    localparam logic [1:0] OTPCT_TH_STD = 2'h0;
    localparam logic [1:0] OTPCT_TH_HIGH = 2'h1;
    localparam logic [1:0] OTPCT_TH_LOW = 2'h2;
    // burn times in nanoseconds
    localparam int unsigned OTPCT_BURN_BASE_NS = 2850;
    localparam int unsigned OTPCT_BURN_BIT_NS = 401000;
    localparam int unsigned OTPCT_EOT_NS = 404000;
    localparam int unsigned OTPCT_NS_PER_CYC = 1_000_000_000 / OTPCT_CLK_HZ;
    localparam int unsigned OTPCT_BURN_BASE_CYC =
        (OTPCT_BURN_BASE_NS + OTPCT_NS_PER_CYC - 1) / OTPCT_NS_PER_CYC;
    localparam int unsigned OTPCT_BURN_BIT_CYC =
        (OTPCT_BURN_BIT_NS + OTPCT_NS_PER_CYC - 1) / OTPCT_NS_PER_CYC;
    localparam int unsigned OTPCT_EOT_CYC =
        (OTPCT_EOT_NS + OTPCT_NS_PER_CYC - 1) / OTPCT_NS_PER_CYC;
    localparam int unsigned OTPCT_CNT_W = 23;
endpackage

/* File: design/otpct_fuse_array.sv */
// model of the antifuse cells with three read thresholds
`timescale 1ns/1ns
`default_nettype none
module otpct_fuse_array (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // burn strobes
    input wire logic burn_word,
    input wire logic [7:0] burn_bits,
    input wire logic burn_done_fuse,
    // read request
    input wire logic [1:0] read_threshold,
    // sensed cells
    output logic [7:0] sense_word,
    output logic sense_done
);
    import otpct_pkg::*;
    typedef struct packed {
        logic [7:0] word;
        logic done;
    } otpct_cells_t;
    otpct_cells_t st, next_st;
    always_comb begin
        next_st = st;
        if (burn_word) begin
            next_st.word = st.word | burn_bits;
        end
        if (burn_done_fuse) begin
            next_st.done = 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // burned cells read 1 at every threshold in this ideal model
    always_comb begin
        sense_word = st.word;
        sense_done = st.done;
        if (read_threshold == OTPCT_TH_HIGH) begin
            sense_word = st.word;
        end
    end
endmodule
`default_nettype wire

/* File: design/otpct_trim.sv */
// customer trim register, fuse sequencing and power-up defaults
`timescale 1ns/1ns
`default_nettype none
// Function
// - 24-bit frame register, address 0x3E, odd parity
// - burn write accepted only before done
// - opcode bits 23:21 select operation
// - default bits occupy 20 down to 13
// - bit 12 done flag, locks trimming
// - high resistance reads 0, else 1
// - blank check loads bits 20:13, high threshold
// - margin read loads register, low threshold
// - word burn 2.85us plus 401us per bit
// - done fuse burn takes 404us
// - peak select maps to peak current code
// - off select maps to off-time code
module otpct_trim (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // decoded frame from the serial link
    input wire logic frame_valid,
    input wire logic [23:0] frame_data,
    // answer frame
    output logic [23:0] read_data,
    output logic read_valid,
    output logic frame_error,
    output logic busy,
    // power-up configuration
    output logic [1:0] high_range_select_1,
    output logic [5:0] peak_current_code_1,
    output logic [3:0] off_time_product_code_1,
    output logic default_single_config_bit,
    output logic default_boost_disable
);
    import otpct_pkg::*;

    typedef enum logic [2:0] {
        OTPCT_ST_BOOT = 3'b000,
        OTPCT_ST_IDLE = 3'b001,
        OTPCT_ST_BURN = 3'b010,
        OTPCT_ST_LOAD = 3'b011
    } otpct_state_t;

    typedef struct packed {
        otpct_state_t state;
        logic [7:0] def_word;
        logic done;
        logic [OTPCT_CNT_W-1:0] cnt;
        logic [1:0] th;
        logic [23:0] read_data;
        logic read_valid;
        logic frame_error;
        logic busy;
        logic [1:0] hr;
        logic [5:0] dac;
        logic [3:0] toff;
        logic ms;
        logic bst;
    } otpct_st_t;

    otpct_st_t st, next_st;
    logic burn_word;
    logic burn_eot;
    logic [7:0] sense_word;
    logic sense_done;

    function automatic logic [5:0] otpct_dac_map(input logic [1:0] sel);
        logic [5:0] r;
        r = 6'h00;
        unique case (sel)
            2'h0: r = 6'h20;
            2'h1: r = 6'h00;
            2'h2: r = 6'h31;
            2'h3: r = 6'h3F;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] otpct_toff_map(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        unique case (sel)
            2'h0: r = 4'hF;
            2'h1: r = 4'hB;
            2'h2: r = 4'h5;
            2'h3: r = 4'h0;
        endcase
        return r;
    endfunction

    function automatic logic [4:0] otpct_popcount(input logic [7:0] w);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 8; i++) begin
            n = n + {4'h0, w[i]};
        end
        return n;
    endfunction

    // register image: opcode, defaults, done flag, reserved zero, parity
    function automatic logic [23:0] otpct_image(input logic [2:0] op,
                                                input logic [7:0] w,
                                                input logic d);
        logic [23:0] f;
        f = 24'h00_0000;
        f[OTPCT_OP_HI:OTPCT_OP_LO] = op;
        f[OTPCT_DEF_HI:OTPCT_DEF_LO] = w;
        f[OTPCT_DONE_BIT] = d;
        f[0] = ~(^f[23:1]);
        return f;
    endfunction

    logic [1:0] f_cmd;
    logic [5:0] f_addr;
    logic [2:0] f_op;
    logic [7:0] f_word;
    logic f_par_ok;
    assign f_cmd = frame_data[23:22];
    assign f_addr = frame_data[21:16];
    // payload after the 8-bit header carries opcode and defaults
    assign f_op = frame_data[15:13];
    assign f_word = frame_data[12:5];
    assign f_par_ok = ^frame_data;

    otpct_fuse_array u_fuses (
        .clk(clk),
        .rst(rst),
        .burn_word(burn_word),
        .burn_bits(st.def_word),
        .burn_done_fuse(burn_eot),
        .read_threshold(st.th),
        .sense_word(sense_word),
        .sense_done(sense_done)
    );

    // fuse writes fire on the final cycle of the burn time
    assign burn_word = (st.state == OTPCT_ST_BURN) && (st.cnt == '0) && (st.th == OTPCT_TH_STD);
    assign burn_eot = (st.state == OTPCT_ST_BURN) && (st.cnt == '0) && (st.th == OTPCT_TH_LOW);

    always_comb begin
        next_st = st;
        next_st.read_valid = 1'b0;
        next_st.frame_error = 1'b0;
        unique case (st.state)
            OTPCT_ST_BOOT: begin
                // latch burned cells as power-up defaults
                next_st.def_word = sense_word;
                next_st.done = sense_done;
                next_st.hr = sense_word[7:6];
                next_st.dac = otpct_dac_map(sense_word[5:4]);
                next_st.toff = otpct_toff_map(sense_word[3:2]);
                next_st.ms = sense_word[1];
                next_st.bst = sense_word[0];
                next_st.state = OTPCT_ST_IDLE;
            end
            OTPCT_ST_IDLE: begin
                if (frame_valid && f_addr == OTPCT_ADDR) begin
                    if (!f_par_ok) begin
                        next_st.frame_error = 1'b1;
                    end else if (f_cmd == OTPCT_CMD_READ) begin
                        next_st.read_data = otpct_image(3'h0, st.def_word, st.done);
                        next_st.read_valid = 1'b1;
                    end else if (f_cmd == OTPCT_CMD_WRITE) begin
                        unique case (f_op)
                            OTPCT_OP_BURN: begin
                                if (!st.done) begin
                                    next_st.def_word = f_word;
                                    next_st.th = OTPCT_TH_STD;
                                    next_st.cnt = OTPCT_CNT_W'(OTPCT_BURN_BASE_CYC
                                        + OTPCT_BURN_BIT_CYC * otpct_popcount(f_word) - 1);
                                    next_st.busy = 1'b1;
                                    next_st.state = OTPCT_ST_BURN;
                                end else begin
                                    next_st.frame_error = 1'b1;
                                end
                            end
                            OTPCT_OP_EOT: begin
                                // repeat issues re-burn the done fuse, so no lock here
                                next_st.th = OTPCT_TH_LOW;
                                next_st.cnt = OTPCT_CNT_W'(OTPCT_EOT_CYC - 1);
                                next_st.busy = 1'b1;
                                next_st.state = OTPCT_ST_BURN;
                            end
                            OTPCT_OP_BLANK: begin
                                next_st.th = OTPCT_TH_HIGH;
                                next_st.state = OTPCT_ST_LOAD;
                            end
                            OTPCT_OP_MARGIN: begin
                                next_st.th = OTPCT_TH_LOW;
                                next_st.state = OTPCT_ST_LOAD;
                            end
                            OTPCT_OP_STD: begin
                                next_st.th = OTPCT_TH_STD;
                                next_st.state = OTPCT_ST_LOAD;
                            end
                            default: begin
                                next_st.frame_error = 1'b1;
                            end
                        endcase
                    end else begin
                        next_st.frame_error = 1'b1;
                    end
                end
            end
            OTPCT_ST_BURN: begin
                if (st.cnt == '0) begin
                    next_st.busy = 1'b0;
                    next_st.th = OTPCT_TH_STD;
                    next_st.state = OTPCT_ST_LOAD;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            OTPCT_ST_LOAD: begin
                // load sensed cells into the register image
                next_st.def_word = sense_word;
                next_st.done = sense_done;
                next_st.state = OTPCT_ST_IDLE;
            end
            default: begin
                next_st.state = OTPCT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.state <= OTPCT_ST_BOOT;
            st.dac <= 6'h20;
            st.toff <= 4'hF;
        end else begin
            st <= next_st;
        end
    end

    assign read_data = st.read_data;
    assign read_valid = st.read_valid;
    assign frame_error = st.frame_error;
    assign busy = st.busy;
    assign high_range_select_1 = st.hr;
    assign peak_current_code_1 = st.dac;
    assign off_time_product_code_1 = st.toff;
    assign default_single_config_bit = st.ms;
    assign default_boost_disable = st.bst;

    chk_read_parity: assert property (@(posedge clk) disable iff (rst)
        read_valid |-> (^read_data) == 1'b1)
        else $error("read frame parity not odd");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        read_valid |-> read_data[11:1] == 11'h000)
        else $error("reserved bits not zero");
    chk_locked_burn: assert property (@(posedge clk) disable iff (rst)
        (st.state == OTPCT_ST_IDLE && st.done && frame_valid && f_op == OTPCT_OP_BURN)
        |=> !busy)
        else $error("burn started after trim done");
    chk_eot_time: assert property (@(posedge clk) disable iff (rst)
        $rose(busy) && st.th == OTPCT_TH_LOW |-> st.cnt == OTPCT_CNT_W'(OTPCT_EOT_CYC - 1))
        else $error("done fuse burn time wrong");
    chk_burn_time: assert property (@(posedge clk) disable iff (rst)
        $rose(busy) && st.th == OTPCT_TH_STD |-> st.cnt == OTPCT_CNT_W'(OTPCT_BURN_BASE_CYC
        + OTPCT_BURN_BIT_CYC * otpct_popcount(st.def_word) - 1))
        else $error("word burn time wrong");
    chk_dac_map: assert property (@(posedge clk) disable iff (rst)
        $past(st.state) == OTPCT_ST_BOOT |-> peak_current_code_1
        == otpct_dac_map(st.def_word[5:4]))
        else $error("peak code mapping wrong");
    chk_toff_map: assert property (@(posedge clk) disable iff (rst)
        $past(st.state) == OTPCT_ST_BOOT |-> off_time_product_code_1
        == otpct_toff_map(st.def_word[3:2]))
        else $error("off code mapping wrong");
    chk_load_after: assert property (@(posedge clk) disable iff (rst)
        st.state == OTPCT_ST_LOAD |=> st.def_word == $past(sense_word))
        else $error("read result not loaded");
endmodule
`default_nettype wire

/* File: bench/otpct_host_model.sv */
// trim host model: frame builder, sender and answer monitor
`timescale 1ns/1ns
`default_nettype none
module otpct_host_model (
    // clock
    input wire logic clk,
    // frames towards the trim block
    output var logic frame_valid,
    output var logic [23:0] frame_data,
    // answers
    input wire logic [23:0] read_data,
    input wire logic read_valid,
    input wire logic frame_error,
    input wire logic busy
);
    import otpct_pkg::*;
    logic [23:0] last_rd = 24'h00_0000;
    logic last_rv = 1'b0;
    logic last_fe = 1'b0;
    int bcnt = 0;

    // quiet link before reset
    task automatic idle();
        frame_valid = 1'b0;
        frame_data = 24'h00_0000;
    endtask

    // answer monitor; flags and busy count cleared by each new frame, last read data kept
    always @(posedge clk) begin
        if (frame_valid === 1'b1) begin
            last_rv <= 1'b0;
            last_fe <= 1'b0;
            bcnt <= 0;
        end else begin
            if (read_valid === 1'b1) begin
                last_rd <= read_data;
                last_rv <= 1'b1;
            end
            if (frame_error === 1'b1) begin
                last_fe <= 1'b1;
            end
            if (busy === 1'b1) begin
                bcnt <= bcnt + 1;
            end
        end
    end

    task automatic put(input logic [23:0] f);
        int n;
        n = 0;
        @(negedge clk);
        frame_valid = 1'b1;
        frame_data = f;
        @(negedge clk);
        frame_valid = 1'b0;
        // released frame shows inverted data
        frame_data = ~f;
        repeat (3) @(negedge clk);
        // let a burn finish before the next command
        while (busy === 1'b1 && n < 80000) begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
    endtask

    task automatic send(input logic [1:0] c, input logic [2:0] op,
                        input logic [7:0] w, input logic bad);
        logic [23:0] f;
        f = {c, OTPCT_ADDR, op, w, 5'h00};
        f[0] = ~^f[23:1] ^ bad;
        put(f);
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the customer trim block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import otpct_pkg::*;
    localparam logic [7:0] WORD = 8'h81;
    localparam int BURN_CYC = OTPCT_BURN_BASE_CYC + 2 * OTPCT_BURN_BIT_CYC;
    logic clk;
    logic rst;
    logic frame_valid;
    logic [23:0] frame_data;
    logic [23:0] read_data;
    logic read_valid;
    logic frame_error;
    logic busy;
    logic [1:0] high_range_select_1;
    logic [5:0] peak_current_code_1;
    logic [3:0] off_time_product_code_1;
    logic default_single_config_bit;
    logic default_boost_disable;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [2:0] loads[3] = '{OTPCT_OP_STD, OTPCT_OP_MARGIN, OTPCT_OP_BLANK};

    otpct_trim uut (.clk(clk), .rst(rst), .frame_valid(frame_valid),
        .frame_data(frame_data), .read_data(read_data), .read_valid(read_valid),
        .frame_error(frame_error), .busy(busy),
        .high_range_select_1(high_range_select_1),
        .peak_current_code_1(peak_current_code_1),
        .off_time_product_code_1(off_time_product_code_1),
        .default_single_config_bit(default_single_config_bit),
        .default_boost_disable(default_boost_disable));
    otpct_host_model u_host (.clk(clk), .frame_valid(frame_valid),
        .frame_data(frame_data), .read_data(read_data), .read_valid(read_valid),
        .frame_error(frame_error), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // read back and compare with the expected register image
    task automatic read_expect(input logic [7:0] w, input logic d);
        u_host.send(OTPCT_CMD_READ, 3'h0, 8'h00, 1'b0);
        check(24'({u_host.last_rv, u_host.last_fe}), 24'h00_0002);
        check(u_host.last_rd, {3'h0, w, d, 11'h000, ~^{w, d}});
    endtask

    task automatic load_all(input logic [7:0] w, input logic d);
        foreach (loads[i]) begin
            u_host.send(OTPCT_CMD_WRITE, loads[i], 8'h00, 1'b0);
            check(24'(u_host.last_fe), 24'h00_0000);
            read_expect(w, d);
        end
    endtask

    initial begin
        u_host.idle();
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        check(24'(peak_current_code_1), 24'h00_0020);
        check(24'(off_time_product_code_1), 24'h00_000F);
        check(24'({high_range_select_1, default_single_config_bit,
                   default_boost_disable}), 24'h00_0000);
        load_all(8'h00, 1'b0);
        u_host.send(OTPCT_CMD_READ, 3'h0, 8'h00, 1'b1);
        check(24'({u_host.last_rv, u_host.last_fe}), 24'h00_0001);
        u_host.put(24'h46_0000);
        check(24'({u_host.last_rv, u_host.last_fe}), 24'h00_0000);
        u_host.send(2'h2, OTPCT_OP_STD, 8'h00, 1'b0);
        check(24'(u_host.last_fe), 24'h00_0001);
        for (int op = 5; op < 7; op++) begin
            u_host.send(OTPCT_CMD_WRITE, 3'(op), 8'h00, 1'b0);
            check(24'(u_host.last_fe), 24'h00_0001);
        end
        repeat (3) begin
            u_host.send(OTPCT_CMD_WRITE, OTPCT_OP_BURN, WORD, 1'b0);
            check(24'(u_host.last_fe), 24'h00_0000);
            check(24'(u_host.bcnt >= BURN_CYC && u_host.bcnt <= BURN_CYC + 1),
                  24'h00_0001);
        end
        repeat (3) begin
            u_host.send(OTPCT_CMD_WRITE, OTPCT_OP_EOT, 8'h00, 1'b0);
            check(24'(u_host.bcnt >= OTPCT_EOT_CYC && u_host.bcnt <= OTPCT_EOT_CYC + 1),
                  24'h00_0001);
        end
        load_all(WORD, 1'b1);
        u_host.send(OTPCT_CMD_WRITE, OTPCT_OP_BURN, 8'h02, 1'b0);
        check(24'({u_host.last_fe, u_host.bcnt == 0}), 24'h00_0003);
        check(24'(peak_current_code_1), 24'h00_0020);
        test_done();
    end

    initial begin
        #(100_000 * 50);
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
